// ==== adc_cfg_pkg.sv ====
`default_nettype none
package adc_cfg_pkg;

	// timing: conversion length as a time, then as whole clock cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS  = 20_000;
	localparam int CONV_CYCLES   =
		(CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// serial word sizes
	localparam logic [4:0] IN_WORD_BITS = 5'h10;
	localparam int         OUT_BITS     = 24;

	// input word field positions, first shifted bit is bit 15
	localparam int FLD_LEAD_MSB = 15;
	localparam int FLD_SGL      = 12;
	localparam int FLD_ODD      = 11;
	localparam int FLD_ADDR_MSB = 10;
	localparam int FLD_EN2      = 7;
	localparam int FLD_IM       = 6;
	localparam int FLD_FA       = 5;
	localparam int FLD_FB       = 4;
	localparam int FLD_SPD      = 3;
	localparam int FLD_GAIN_MSB = 2;

	// leading three-bit field patterns
	localparam logic [2:0] LEAD_LOAD  = 3'h5;
	localparam logic [2:0] LEAD_KEEP0 = 3'h0;
	localparam logic [2:0] LEAD_KEEP1 = 3'h4;

	// output word layout
	localparam int OUT_EOC = 23;
	localparam int OUT_DMY = 22;
	localparam int OUT_SIG = 21;
	localparam int OUT_MSB = 20;

	// mux code of the shared return input
	localparam logic [4:0] MUX_COM = 5'h10;

	// channel selection group
	typedef struct packed {
		logic       single_ended_select;
		logic       polarity_select;
		logic       chan_addr_hi;
		logic       chan_addr_mid;
		logic       chan_addr_lo;
	} chan_cfg_s;

	// conversion setup group
	typedef struct packed {
		logic       temp_sensor_select;
		logic       reject_freq_hi;
		logic       reject_freq_lo;
		logic       rate_double_select;
		logic       gain_sel_2;
		logic       gain_sel_1;
		logic       gain_sel_0;
	} conv_cfg_s;

	// power-up values: ch0 positive, ch1 negative; 50/60 Hz, 1x, gain 1
	localparam chan_cfg_s CHAN_CFG_RST = '0;
	localparam conv_cfg_s CONV_CFG_RST = '0;

	// register map, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CHAN   = 8'h08;
	localparam logic [7:0] REG_CONV   = 8'h0C;
	localparam logic [7:0] REG_RESULT = 8'h10;

	// register fields
	localparam int CTRL_RESTART   = 0;
	localparam int STAT_BUSY      = 0;
	localparam int STAT_BAD_LEAD  = 1;
	localparam int STAT_CNT_LSB   = 8;
	localparam int RESULT_W       = 22;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// ==== adc_serial_config_decoder.sv ====
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_decoder
	import adc_cfg_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES
) (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	// axi4-lite write address
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output var  logic        o_awready,
	// axi4-lite write data
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output var  logic        o_wready,
	// axi4-lite write response
	output var  logic [1:0]  o_bresp,
	output var  logic        o_bvalid,
	input  wire logic        i_bready,
	// axi4-lite read address
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output var  logic        o_arready,
	// axi4-lite read data
	output var  logic [31:0] o_rdata,
	output var  logic [1:0]  o_rresp,
	output var  logic        o_rvalid,
	input  wire logic        i_rready,
	// serial link pins
	input  wire logic        i_cs_n,
	input  wire logic        i_sck,
	input  wire logic        i_sdi,
	output var  logic        o_sdo,
	// analog front-end controls
	output var  logic [4:0]  o_mux_pos,
	output var  logic [4:0]  o_mux_neg,
	output var  logic        o_temp_sel,
	output var  logic [1:0]  o_reject_freq,
	output var  logic        o_rate_2x,
	output var  logic        o_auto_cal,
	output var  logic [3:0]  o_gain_log2,
	output var  logic        o_conv_busy
);

	localparam int CNT_W = $clog2(CONV_LEN + 1);

	// mux code for one side of the selected input
	function automatic logic [4:0] mux_code(input chan_cfg_s c,
		input logic neg);
		logic [4:0] code;
		code = {1'b0, c.chan_addr_hi, c.chan_addr_mid, c.chan_addr_lo,
			c.polarity_select};
		if (neg && c.single_ended_select) begin
			code = MUX_COM;
		end else if (neg) begin
			code[0] = ~c.polarity_select;
		end
		return code;
	endfunction

	// pin synchronisers: bit 2 cs_n, bit 1 sck, bit 0 sdi
	logic [2:0] pin_meta_q, pin_meta_d;
	logic [2:0] pin_sync_q, pin_sync_d;
	logic [2:0] pin_prev_q, pin_prev_d;

	// serial framing state
	logic [15:0]        in_sh_q,    in_sh_d;     // captured input bits
	logic [4:0]         bit_cnt_q,  bit_cnt_d;   // saturating bit count
	logic [OUT_BITS-1:0] out_sh_q,  out_sh_d;    // output shifter
	logic               frame_ok_q, frame_ok_d;  // frame began when idle
	logic               sdo_q,      sdo_d;

	// configuration and conversion state
	chan_cfg_s          chan_q,     chan_d;
	conv_cfg_s          conv_q,     conv_d;
	logic               busy_q,     busy_d;
	logic [CNT_W-1:0]   cnt_q,      cnt_d;
	logic [OUT_BITS-1:0] word_q,    word_d;      // last finished result
	logic               sig_tgl_q,  sig_tgl_d;
	logic               bad_lead_q, bad_lead_d;
	logic [7:0]         loads_q,    loads_d;     // complete 16-bit frame count
	logic [4:0]         pos_q, pos_d, neg_q, neg_d;
	logic [3:0]         glog_q,     glog_d;

	// bus slave state
	logic               awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
	logic               aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [7:0]         waddr_q, waddr_d;
	logic [31:0]        wdata_q, wdata_d;
	logic [3:0]         wstrb_q, wstrb_d;
	logic               bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]         bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]        rdata_q, rdata_d;
	logic [RESULT_W-1:0] result_q, result_d;     // stand-in sample value
	logic               restart;                 // software restart pulse

	// edge events seen on the synchronised pins
	logic cs_fall, cs_rise, sck_rise, sck_fall, in_frame, frame_end;
	assign in_frame  = ~pin_sync_q[2];
	assign cs_fall   = pin_prev_q[2] & ~pin_sync_q[2];
	assign cs_rise   = ~pin_prev_q[2] & pin_sync_q[2];
	assign sck_rise  = ~pin_prev_q[1] & pin_sync_q[1] & in_frame;
	assign sck_fall  = pin_prev_q[1] & ~pin_sync_q[1] & in_frame;
	assign frame_end = cs_rise & frame_ok_q;

	// two flops before any logic looks at a pin
	always_comb begin
		pin_meta_d = {i_cs_n, i_sck, i_sdi};
		pin_sync_d = pin_meta_q;
		pin_prev_d = pin_sync_q;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_meta_q <= 3'h4;
			pin_sync_q <= 3'h4;
			pin_prev_q <= 3'h4;
		end else begin
			pin_meta_q <= pin_meta_d;
			pin_sync_q <= pin_sync_d;
			pin_prev_q <= pin_prev_d;
		end
	end

	// serial shifting; a frame begun mid-conversion is ignored whole
	always_comb begin
		in_sh_d    = in_sh_q;
		bit_cnt_d  = bit_cnt_q;
		out_sh_d   = out_sh_q;
		frame_ok_d = frame_ok_q;
		if (cs_fall) begin
			frame_ok_d = ~busy_q;
			bit_cnt_d  = '0;
			out_sh_d   = word_q;
		end
		// only the first sixteen bits count
		if (sck_rise && frame_ok_q && bit_cnt_q < IN_WORD_BITS) begin
			in_sh_d   = {in_sh_q[14:0], pin_sync_q[0]};
			bit_cnt_d = bit_cnt_q + 5'h01;
		end
		if (sck_fall && frame_ok_q) begin
			out_sh_d = {out_sh_q[OUT_BITS-2:0], 1'b0};
		end
		if (cs_rise) begin
			frame_ok_d = 1'b0;
		end
		// outside a frame the pin shows conversion_done_n
		if (!in_frame || !frame_ok_q) begin
			sdo_d = busy_q;
		end else begin
			sdo_d = out_sh_q[OUT_BITS-1];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			in_sh_q    <= '0;
			bit_cnt_q  <= '0;
			out_sh_q   <= '0;
			frame_ok_q <= 1'b0;
			sdo_q      <= 1'b1;
		end else begin
			in_sh_q    <= in_sh_d;
			bit_cnt_q  <= bit_cnt_d;
			out_sh_q   <= out_sh_d;
			frame_ok_q <= frame_ok_d;
			sdo_q      <= sdo_d;
		end
	end

	// word decode and conversion sequencing
	always_comb begin
		logic [2:0] lead;
		logic       zero_code;
		lead       = in_sh_q[FLD_LEAD_MSB -: 3];
		zero_code  = result_q[OUT_MSB:0] == '0;
		chan_d     = chan_q;
		conv_d     = conv_q;
		busy_d     = busy_q;
		cnt_d      = cnt_q;
		word_d     = word_q;
		sig_tgl_d  = sig_tgl_q;
		bad_lead_d = bad_lead_q;
		loads_d    = loads_q;
		if (frame_end && bit_cnt_q == IN_WORD_BITS) begin
			loads_d = loads_q + 8'h01;
			if (lead == LEAD_LOAD) begin
				bad_lead_d = 1'b0;
				chan_d.single_ended_select = in_sh_q[FLD_SGL];
				chan_d.polarity_select     = in_sh_q[FLD_ODD];
				chan_d.chan_addr_hi        = in_sh_q[FLD_ADDR_MSB];
				chan_d.chan_addr_mid       = in_sh_q[FLD_ADDR_MSB-1];
				chan_d.chan_addr_lo        = in_sh_q[FLD_ADDR_MSB-2];
				if (in_sh_q[FLD_EN2]) begin
					conv_d.temp_sensor_select = in_sh_q[FLD_IM];
					conv_d.reject_freq_hi     = in_sh_q[FLD_FA];
					conv_d.reject_freq_lo     = in_sh_q[FLD_FB];
					conv_d.rate_double_select = in_sh_q[FLD_SPD];
					conv_d.gain_sel_2 = in_sh_q[FLD_GAIN_MSB];
					conv_d.gain_sel_1 = in_sh_q[FLD_GAIN_MSB-1];
					conv_d.gain_sel_0 = in_sh_q[FLD_GAIN_MSB-2];
				end
			end else if (lead == LEAD_KEEP0 || lead == LEAD_KEEP1) begin
				bad_lead_d = 1'b0;
			end else begin
				bad_lead_d = 1'b1;
			end
		end
		if (frame_end || restart) begin
			busy_d = 1'b1;
			cnt_d  = '0;
		end else if (busy_q && cnt_q == CNT_W'(CONV_LEN - 1)) begin
			busy_d            = 1'b0;
			sig_tgl_d         = ~sig_tgl_q;
			word_d            = '0;
			word_d[OUT_EOC]   = 1'b0;
			word_d[OUT_DMY]   = 1'b0;
			word_d[OUT_SIG]   = result_q[OUT_SIG];
			word_d[OUT_MSB:0] = result_q[OUT_MSB:0];
			// sign wanders on zero in 2x
			if (conv_q.rate_double_select && zero_code) begin
				word_d[OUT_SIG] = sig_tgl_q;
			end
		end else if (busy_q) begin
			cnt_d = cnt_q + CNT_W'(1);
		end
		pos_d = mux_code(chan_q, 1'b0);
		neg_d = mux_code(chan_q, 1'b1);
		// gain 1,4,8..256 as a power of two
		if ({conv_q.gain_sel_2, conv_q.gain_sel_1, conv_q.gain_sel_0}
			== 3'h0) begin
			glog_d = 4'h0;
		end else begin
			glog_d = {1'b0, conv_q.gain_sel_2, conv_q.gain_sel_1,
				conv_q.gain_sel_0} + 4'h1;
		end
	end

	// busy from reset starts the first conversion
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chan_q     <= CHAN_CFG_RST;
			conv_q     <= CONV_CFG_RST;
			busy_q     <= 1'b1;
			cnt_q      <= '0;
			word_q     <= '0;
			sig_tgl_q  <= 1'b0;
			bad_lead_q <= 1'b0;
			loads_q    <= '0;
			pos_q      <= 5'h00;
			neg_q      <= 5'h01;
			glog_q     <= 4'h0;
		end else begin
			chan_q     <= chan_d;
			conv_q     <= conv_d;
			busy_q     <= busy_d;
			cnt_q      <= cnt_d;
			word_q     <= word_d;
			sig_tgl_q  <= sig_tgl_d;
			bad_lead_q <= bad_lead_d;
			loads_q    <= loads_d;
			pos_q      <= pos_d;
			neg_q      <= neg_d;
			glog_q     <= glog_d;
		end
	end

	// axi4-lite slave: address and data taken in either order
	always_comb begin
		logic aw_fire, w_fire, ar_fire;
		aw_fire  = i_awvalid & awr_q;
		w_fire   = i_wvalid & wr_q;
		ar_fire  = i_arvalid & arr_q;
		aw_got_d = aw_got_q | aw_fire;
		w_got_d  = w_got_q | w_fire;
		waddr_d  = aw_fire ? i_awaddr : waddr_q;
		wdata_d  = w_fire ? i_wdata : wdata_q;
		wstrb_d  = w_fire ? i_wstrb : wstrb_q;
		bvalid_d = bvalid_q & ~i_bready;
		bresp_d  = bresp_q;
		result_d = result_q;
		restart  = 1'b0;
		// write happens once both halves are in hand
		if (aw_got_d && w_got_d && !bvalid_q) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = RESP_OKAY;
			case (waddr_d)
				REG_CTRL: begin
					restart = wstrb_d[0] & wdata_d[CTRL_RESTART];
				end
				REG_RESULT: begin
					for (int b = 0; b < 3; b++) begin
						if (wstrb_d[b]) begin
							result_d[b*8 +: 8] = wdata_d[b*8 +: 8];
						end
					end
				end
				REG_STATUS, REG_CHAN, REG_CONV: begin
					// read-only, write dropped
				end
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		awr_d = ~aw_got_d & ~bvalid_d;
		wr_d  = ~w_got_d & ~bvalid_d;
		// reads answer one cycle after the address is taken
		rvalid_d = rvalid_q & ~i_rready;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (ar_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			rdata_d  = '0;
			case (i_araddr)
				REG_CTRL: rdata_d = '0;
				REG_STATUS: begin
					rdata_d[STAT_BUSY]             = busy_q;
					rdata_d[STAT_BAD_LEAD]         = bad_lead_q;
					rdata_d[STAT_CNT_LSB +: 8]     = loads_q;
				end
				REG_CHAN:   rdata_d[4:0] = chan_q;
				REG_CONV:   rdata_d[6:0] = conv_q;
				REG_RESULT: rdata_d[RESULT_W-1:0] = result_q;
				default:    rresp_d = RESP_SLVERR;
			endcase
		end
		arr_d = ~rvalid_d;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			awr_q    <= 1'b0;
			wr_q     <= 1'b0;
			arr_q    <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			waddr_q  <= '0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
			result_q <= '0;
		end else begin
			awr_q    <= awr_d;
			wr_q     <= wr_d;
			arr_q    <= arr_d;
			aw_got_q <= aw_got_d;
			w_got_q  <= w_got_d;
			waddr_q  <= waddr_d;
			wdata_q  <= wdata_d;
			wstrb_q  <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
			result_q <= result_d;
		end
	end

	// outputs straight from flops, o_auto_cal through one inverter
	assign o_awready     = awr_q;
	assign o_wready      = wr_q;
	assign o_bvalid      = bvalid_q;
	assign o_bresp       = bresp_q;
	assign o_arready     = arr_q;
	assign o_rvalid      = rvalid_q;
	assign o_rresp       = rresp_q;
	assign o_rdata       = rdata_q;
	assign o_sdo         = sdo_q;
	assign o_mux_pos     = pos_q;
	assign o_mux_neg     = neg_q;
	assign o_temp_sel    = conv_q.temp_sensor_select;
	assign o_reject_freq = {conv_q.reject_freq_hi, conv_q.reject_freq_lo};
	assign o_rate_2x     = conv_q.rate_double_select;
	assign o_auto_cal    = ~conv_q.rate_double_select;
	assign o_gain_log2   = glog_q;
	assign o_conv_busy   = busy_q;

endmodule
`default_nettype wire

// ==== adc_cfg_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_chk
	import adc_cfg_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES
) (
	// clock and reset
	input wire logic       i_mclk,
	input wire logic       i_rst_n,
	// bus handshakes
	input wire logic       i_awvalid,
	input wire logic       o_awready,
	input wire logic       i_wvalid,
	input wire logic       o_wready,
	input wire logic       o_bvalid,
	input wire logic       i_arvalid,
	input wire logic       o_arready,
	input wire logic       o_rvalid,
	// serial link
	input wire logic       i_cs_n,
	input wire logic       o_sdo,
	// front-end controls
	input wire logic [4:0] o_mux_pos,
	input wire logic [4:0] o_mux_neg,
	input wire logic       o_temp_sel,
	input wire logic [1:0] o_reject_freq,
	input wire logic       o_rate_2x,
	input wire logic       o_auto_cal,
	input wire logic [3:0] o_gain_log2,
	input wire logic       o_conv_busy
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	logic [15:0] busy_cnt_q, busy_cnt_d;   // cycles busy so far
	logic        first_q, first_d;         // first conversion since reset
	logic        cs_q, cs_d;               // select seen last cycle
	logic [3:0]  since_cs_q, since_cs_d;   // cycles since select rose

	// helper next values; the count saturates so it never wraps to a
	// small value long after a frame
	always_comb begin
		busy_cnt_d = o_conv_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
		first_d = first_q & o_conv_busy;
		cs_d = i_cs_n;
		since_cs_d = (since_cs_q == 4'hF) ? 4'hF : since_cs_q + 4'h1;
		if (i_cs_n && !cs_q) begin
			since_cs_d = 4'h0;
		end
	end

	// helper registers
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_cnt_q <= 16'h0000;
			first_q <= 1'b1;
			cs_q <= 1'b1;
			since_cs_q <= 4'hF;
		end else begin
			busy_cnt_q <= busy_cnt_d;
			first_q <= first_d;
			cs_q <= cs_d;
			since_cs_q <= since_cs_d;
		end
	end

	sequence s_wr_taken;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence s_rd_taken;
		i_arvalid && o_arready;
	endsequence
	// select parked high and the busy flag settled
	sequence s_cs_idle;
		i_cs_n [*8] ##0 $stable(o_conv_busy);
	endsequence

	property p_auto_cal;
		o_auto_cal == !o_rate_2x;
	endproperty
	property p_diff_pair;
		o_mux_neg != MUX_COM |-> (o_mux_pos ^ o_mux_neg) == 5'h01;
	endproperty
	property p_se_pos;
		o_mux_neg == MUX_COM |-> !o_mux_pos[4];
	endproperty
	property p_gain_code;
		o_gain_log2 != 4'h1 && o_gain_log2 <= 4'h8;
	endproperty
	property p_cfg_keep;
		$changed({o_mux_pos, o_mux_neg, o_temp_sel, o_reject_freq,
			o_rate_2x, o_gain_log2}) |-> since_cs_q < 4'hA;
	endproperty
	property p_first_conv;
		$rose(i_rst_n) |-> o_conv_busy [*3];
	endproperty
	property p_busy_len;
		$fell(o_conv_busy) && !first_q |-> busy_cnt_q == 16'(CONV_LEN);
	endproperty
	property p_sdo_idle;
		s_cs_idle |-> o_sdo == o_conv_busy;
	endproperty
	property p_wr_answer;
		s_wr_taken |=> o_bvalid;
	endproperty
	property p_rd_answer;
		s_rd_taken |=> o_rvalid;
	endproperty

	a_auto_cal: assert property (p_auto_cal)
		else $error("auto calibration not the inverse of 2x rate");
	a_diff_pair: assert property (p_diff_pair)
		else $error("differential inputs not an adjacent pair");
	a_se_pos: assert property (p_se_pos)
		else $error("single-ended positive input out of range");
	a_gain_code: assert property (p_gain_code)
		else $error("gain setting outside the gain table");
	a_cfg_keep: assert property (p_cfg_keep)
		else $error("settings changed without a frame end");
	a_first_conv: assert property (p_first_conv)
		else $error("no conversion running after reset");
	a_busy_len: assert property (p_busy_len)
		else $error("conversion length wrong");
	a_sdo_idle: assert property (p_sdo_idle)
		else $error("idle data out differs from done flag");
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response late");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read data late");
endmodule
`default_nettype wire

// ==== host_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// serial link pins toward the device
	output var  logic o_cs_n,
	output var  logic o_sck,
	output var  logic o_sdi,
	input  wire logic i_sdo
);
	localparam int HALF_NS = 80;   // half of the link clock period

	// idle: deselected, link clock parked low
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_sdi = 1'b0;
	end

	// one frame; device bits are taken just before each rise, since
	// the device moves its data line only after falls
	task automatic send(input logic [15:0] w, input int nb,
		output logic [15:0] seen);
		seen = 16'h0000;
		o_cs_n = 1'b0;
		#(2 * HALF_NS);
		for (int k = 0; k < nb; k++) begin
			o_sdi = w[15 - k];
			#(HALF_NS);
			seen = {seen[14:0], i_sdo};
			o_sck = 1'b1;
			#(HALF_NS);
			o_sck = 1'b0;
		end
		#(HALF_NS);
		o_cs_n = 1'b1;
		// released line: show the inverse, never a stale level
		o_sdi = ~o_sdi;
	endtask
endmodule
`default_nettype wire

// ==== adc_serial_config_decoder_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_decoder_bench
	import adc_cfg_pkg::*;
;
	localparam int CONV_SIM = 400;   // longer than a frame on purpose
	typedef struct packed {
		logic [15:0] w;
		logic [4:0]  pos;
		logic [4:0]  neg;
		logic        t;
		logic [1:0]  rej;
		logic        r2x;
		logic [3:0]  g;
	} row_s;

	logic        mclk, rst_n;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, data;
	logic [3:0]  wstrb, gain_log2;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp, reject_freq;
	logic        cs_n, sck, sdi, sdo;
	logic [4:0]  mux_pos, mux_neg;
	logic        temp_sel, rate_2x, auto_cal, conv_busy;
	logic [15:0] seen;
	int          n_fail, compares;
	row_s        dflt;
	row_s rows [11] = '{
		'{16'hABA1, 5'h07, 5'h06, 1'h0, 2'h2, 1'h0, 4'h2},
		'{16'hBFDF, 5'h0F, 5'h10, 1'h1, 2'h1, 1'h1, 4'h8},
		'{16'h9080, 5'h0F, 5'h10, 1'h1, 2'h1, 1'h1, 4'h8},
		'{16'h0DB3, 5'h0F, 5'h10, 1'h1, 2'h1, 1'h1, 4'h8},
		'{16'hB270, 5'h04, 5'h10, 1'h1, 2'h1, 1'h1, 4'h8},
		'{16'hA080, 5'h00, 5'h01, 1'h0, 2'h0, 1'h0, 4'h0},
		'{16'hA7B2, 5'h0E, 5'h0F, 1'h0, 2'h3, 1'h0, 4'h3},
		'{16'hA883, 5'h01, 5'h00, 1'h0, 2'h0, 1'h0, 4'h4},
		'{16'hB984, 5'h03, 5'h10, 1'h0, 2'h0, 1'h0, 4'h5},
		'{16'hAE85, 5'h0D, 5'h0C, 1'h0, 2'h0, 1'h0, 4'h6},
		'{16'hB486, 5'h08, 5'h10, 1'h0, 2'h0, 1'h0, 4'h7}};

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	adc_serial_config_decoder #(.CONV_LEN(CONV_SIM)) i_adc_serial_config_decoder (
		.i_mclk(mclk), .i_rst_n(rst_n),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_cs_n(cs_n), .i_sck(sck), .i_sdi(sdi), .o_sdo(sdo),
		.o_mux_pos(mux_pos), .o_mux_neg(mux_neg), .o_temp_sel(temp_sel),
		.o_reject_freq(reject_freq), .o_rate_2x(rate_2x),
		.o_auto_cal(auto_cal), .o_gain_log2(gain_log2),
		.o_conv_busy(conv_busy));

	host_link_model i_host_link_model (
		.o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi), .i_sdo(sdo));

	task automatic summarize();
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask

	// a bound ran out: count it and stop
	task automatic hang(input string nm);
		$display("mismatch %s exp done got hang", nm);
		n_fail++;
		summarize();
	endtask

	// all front-end controls except o_conv_busy at once; auto-cal is the inverse of 2x
	task automatic chk_cfg(input row_s r);
		chk("cfg", 32'({r.pos, r.neg, r.t, r.rej, r.r2x, ~r.r2x, r.g}),
			32'({mux_pos, mux_neg, temp_sel, reject_freq, rate_2x,
			auto_cal, gain_log2}));
	endtask

	// address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		r = bresp;
		if (n >= 50) hang("write");
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (n >= 50) hang("read");
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (conv_busy !== 1'b0 && n < 1000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 1000) hang("idle");
	endtask

	// frames only once the conversion is over
	task automatic apply(input logic [15:0] w, input int nb);
		wait_idle();
		i_host_link_model.send(w, nb, seen);
		repeat (10) @(negedge mclk);
		chk("busy", 32'h0000_0001, 32'(conv_busy));
		wait_idle();
	endtask

	// defaults and a running conversion right after release
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk_cfg(dflt);
		chk("busy0", 32'h0000_0001, 32'(conv_busy));
		repeat (2) @(posedge mclk);
	endtask

	initial begin
		rst_n = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		wstrb = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		n_fail = 0;
		compares = 0;
		dflt = '{16'h0000, 5'h00, 5'h01, 1'h0, 2'h0, 1'h0, 4'h0};
		do_reset();
		// result taken at the end of the first conversion
		axi_wr(REG_RESULT, 32'h002A_5A3C, resp);
		for (int i = 0; i < 11; i++) begin
			apply(rows[i].w, 16);
			chk_cfg(rows[i]);
			chk("sdo_word", 32'h0000_2A5A, 32'(seen));
		end
		// a frame opened while converting is dropped whole
		apply(rows[0].w, 16);
		i_host_link_model.send(rows[0].w, 16, seen);
		repeat (10) @(negedge mclk);
		i_host_link_model.send(rows[1].w, 16, seen);
		chk("busy_sdo", 32'h0000_FFFF, 32'(seen));
		wait_idle();
		chk_cfg(rows[0]);
		apply(16'hFFFF, 16);
		chk_cfg(rows[0]);
		axi_rd(REG_STATUS, data, resp);
		chk("bad_lead", 32'h0000_0001, 32'(data[STAT_BAD_LEAD]));
		apply(rows[1].w, 8);
		chk_cfg(rows[0]);
		axi_rd(REG_CHAN, data, resp);
		chk("chan", 32'h0000_000B, data);
		axi_rd(REG_CONV, data, resp);
		chk("conv", 32'h0000_0021, data);
		axi_wr(REG_CHAN, 32'h0000_001F, resp);
		chk("ro_resp", 32'(RESP_OKAY), 32'(resp));
		chk_cfg(rows[0]);
		axi_wr(8'h40, 32'h0000_0001, resp);
		chk("unmapped_wr", 32'(RESP_SLVERR), 32'(resp));
		axi_rd(8'h40, data, resp);
		chk("unmapped_rd", 32'(RESP_SLVERR), 32'(resp));
		chk("unmapped_data", 32'h0000_0000, data);
		axi_rd(REG_RESULT, data, resp);
		chk("result", 32'h002A_5A3C, data);
		axi_wr(REG_CTRL, 32'h0000_0001, resp);
		repeat (5) @(negedge mclk);
		chk("restart", 32'h0000_0001, 32'(conv_busy));
		wait_idle();
		// second reset in mid-run brings the defaults back
		do_reset();
		wait_idle();
		summarize();
	end
endmodule

bind adc_serial_config_decoder adc_cfg_chk #(.CONV_LEN(CONV_LEN)) i_adc_cfg_chk (
	.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
	.o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
	.o_bvalid(o_bvalid), .i_arvalid(i_arvalid), .o_arready(o_arready),
	.o_rvalid(o_rvalid), .i_cs_n(i_cs_n), .o_sdo(o_sdo),
	.o_mux_pos(o_mux_pos), .o_mux_neg(o_mux_neg), .o_temp_sel(o_temp_sel),
	.o_reject_freq(o_reject_freq), .o_rate_2x(o_rate_2x),
	.o_auto_cal(o_auto_cal), .o_gain_log2(o_gain_log2),
	.o_conv_busy(o_conv_busy));
`default_nettype wire
